/* File: common/cdmo_pkg.sv */
package cdmo_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned PADDR_W = 12;
  localparam logic [11:0] OFS_ADDR = 12'h000;
  localparam logic [11:0] OFS_COUNT = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  localparam logic [11:0] OFS_MASK = 12'h010;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int unsigned COUNT_W = 14;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_DIR_BIT = 1;
  localparam int unsigned CTRL_IRQ_BIT = 2;
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam logic DIR_SDRAM_TO_CARD = 1'b1;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [13:0] COUNT_RST = 14'h0000;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic STAT_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} cdmo_state_type;

endpackage

/* File: rtl/cdmo_addr_counter.sv */
`timescale 1ns/100ps
module cdmo_addr_counter #(
  parameter int unsigned W = 32,
  parameter logic [31:0] STEP = cdmo_pkg::ADDR_STEP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic step,
  output logic [W-1:0] value
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 2 || W > 32) begin : g_bad_width
    $error("cdmo_addr_counter: width must be 2..32");
  end

  logic [W-1:0] value_ff;

  // ----------------------------------------------------------------
  // Counter; a load beats a step
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= cdmo_pkg::ADDR_RST[W-1:0];
    end else if (load) begin
      value_ff <= load_value;
    end else if (step) begin
      value_ff <= value_ff + STEP[W-1:0];
    end
  end

  assign value = value_ff;

endmodule // cdmo_addr_counter

/* File: rtl/cdmo_word_counter.sv */
`timescale 1ns/100ps
module cdmo_word_counter #(
  parameter int unsigned W = cdmo_pkg::COUNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic dec,
  output logic [W-1:0] value,
  output logic last
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 1 || W > 31) begin : g_bad_width
    $error("cdmo_word_counter: width must be 1..31");
  end

  logic [W-1:0] value_ff;

  // ----------------------------------------------------------------
  // Down counter; never wraps below zero
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= cdmo_pkg::COUNT_RST[W-1:0];
    end else if (load) begin
      value_ff <= load_value;
    end else if (dec && value_ff != '0) begin
      value_ff <= value_ff - W'(1);
    end
  end

  assign value = value_ff;
  assign last = (value_ff == W'(1));

endmodule // cdmo_word_counter

/* File: rtl/cdmo_channel_top.sv */
`timescale 1ns/100ps
module cdmo_channel_top #(
  parameter int unsigned COUNT_W = cdmo_pkg::COUNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic sdram_req,
  output logic sdram_write,
  output logic [31:0] sdram_addr,
  output logic [31:0] sdram_wdata,
  input wire logic [31:0] sdram_rdata,
  input wire logic sdram_ack,
  output logic card_req,
  output logic card_write,
  output logic [31:0] card_wdata,
  input wire logic [31:0] card_rdata,
  input wire logic card_ack
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (COUNT_W < 1 || COUNT_W > 31) begin : g_bad_count
    $error("cdmo_channel_top: COUNT_W must be 1..31");
  end

  cdmo_pkg::cdmo_state_type state_ff;
  cdmo_pkg::cdmo_state_type nxt_state;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  logic enable_ff;
  logic dir_ff;
  logic irq_req_en_ff;
  logic done_ff;
  logic mask_ff;
  logic [31:0] data_ff;
  logic sdram_req_ff;
  logic card_req_ff;
  logic rw_write_ff;
  logic [31:0] cur_addr;
  logic [COUNT_W-1:0] words_left;
  logic last_word;
  logic setup_phase;
  logic addr_hit;
  logic wr_en;
  logic idle;
  logic src_ack;
  logic dst_ack;
  logic word_done;
  logic done_event;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pready_ff & pwrite;
  assign idle = (state_ff == cdmo_pkg::ST_IDLE);
  assign addr_hit = (paddr == cdmo_pkg::OFS_ADDR) || (paddr == cdmo_pkg::OFS_COUNT) ||
                    (paddr == cdmo_pkg::OFS_CTRL) || (paddr == cdmo_pkg::OFS_STAT) ||
                    (paddr == cdmo_pkg::OFS_MASK);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      cdmo_pkg::OFS_ADDR: rd_mux = cur_addr;
      cdmo_pkg::OFS_COUNT: rd_mux[COUNT_W-1:0] = words_left;
      cdmo_pkg::OFS_CTRL: begin
        rd_mux[cdmo_pkg::CTRL_EN_BIT] = enable_ff;
        rd_mux[cdmo_pkg::CTRL_DIR_BIT] = dir_ff;
        rd_mux[cdmo_pkg::CTRL_IRQ_BIT] = irq_req_en_ff;
      end
      cdmo_pkg::OFS_STAT: rd_mux[cdmo_pkg::STAT_DONE_BIT] = done_ff;
      cdmo_pkg::OFS_MASK: rd_mux[cdmo_pkg::STAT_DONE_BIT] = mask_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero wait states: the answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup_phase & ~addr_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // enable bit, cleared by hardware at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= cdmo_pkg::CTRL_BIT_RST;
    end else if (wr_en && paddr == cdmo_pkg::OFS_CTRL) begin
      enable_ff <= pwdata[cdmo_pkg::CTRL_EN_BIT];
    end else if (done_event) begin
      enable_ff <= 1'b0;
    end
  end

  // Direction is frozen while a transfer runs so the handshake never flips side
  // direction select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= cdmo_pkg::CTRL_BIT_RST;
    end else if (wr_en && paddr == cdmo_pkg::OFS_CTRL && idle) begin
      dir_ff <= pwdata[cdmo_pkg::CTRL_DIR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_en_ff <= cdmo_pkg::CTRL_BIT_RST;
    end else if (wr_en && paddr == cdmo_pkg::OFS_CTRL) begin
      irq_req_en_ff <= pwdata[cdmo_pkg::CTRL_IRQ_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  // completion sets status only when requested
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= cdmo_pkg::STAT_RST;
    end else if (done_event && irq_req_en_ff) begin
      done_ff <= 1'b1;
    end else if (wr_en && paddr == cdmo_pkg::OFS_STAT && pwdata[cdmo_pkg::STAT_DONE_BIT]) begin
      done_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= cdmo_pkg::MASK_RST;
    end else if (wr_en && paddr == cdmo_pkg::OFS_MASK) begin
      mask_ff <= pwdata[cdmo_pkg::STAT_DONE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_ff & mask_ff;
    end
  end

  // ----------------------------------------------------------------
  // Address and word counters
  // ----------------------------------------------------------------
  // Loads are ignored while busy; software sets up before enabling
  // full 32-bit start address load
  cdmo_addr_counter #(
    .W(32),
    .STEP(cdmo_pkg::ADDR_STEP)
  ) u_addr (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_en && paddr == cdmo_pkg::OFS_ADDR && idle),
    .load_value(pwdata),
    .step(word_done),
    .value(cur_addr)
  );

  // 14-bit size load, upper bits dropped
  cdmo_word_counter #(
    .W(COUNT_W)
  ) u_count (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_en && paddr == cdmo_pkg::OFS_COUNT && idle),
    .load_value(pwdata[COUNT_W-1:0]),
    .dec(word_done),
    .value(words_left),
    .last(last_word)
  );

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  assign src_ack = (dir_ff == cdmo_pkg::DIR_SDRAM_TO_CARD) ? sdram_ack : card_ack;
  assign dst_ack = (dir_ff == cdmo_pkg::DIR_SDRAM_TO_CARD) ? card_ack : sdram_ack;
  assign word_done = (state_ff == cdmo_pkg::ST_WRITE) && dst_ack;
  assign done_event = (state_ff == cdmo_pkg::ST_DONE);

  // Clearing enable stops only at a word boundary; a started handshake is finished
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cdmo_pkg::ST_IDLE: begin
        if (enable_ff) begin
          nxt_state = (words_left == '0) ? cdmo_pkg::ST_DONE : cdmo_pkg::ST_READ;
        end
      end
      cdmo_pkg::ST_READ: begin
        if (src_ack) begin
          nxt_state = cdmo_pkg::ST_WRITE;
        end
      end
      cdmo_pkg::ST_WRITE: begin
        if (dst_ack) begin
          if (last_word) begin
            nxt_state = cdmo_pkg::ST_DONE;
          end else if (!enable_ff) begin
            nxt_state = cdmo_pkg::ST_IDLE;
          end else begin
            nxt_state = cdmo_pkg::ST_READ;
          end
        end
      end
      cdmo_pkg::ST_DONE: nxt_state = cdmo_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= cdmo_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // route read and write sides by direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdram_req_ff <= 1'b0;
      card_req_ff <= 1'b0;
      rw_write_ff <= 1'b0;
    end else begin
      sdram_req_ff <= (nxt_state == cdmo_pkg::ST_READ && dir_ff) ||
                      (nxt_state == cdmo_pkg::ST_WRITE && !dir_ff);
      card_req_ff <= (nxt_state == cdmo_pkg::ST_READ && !dir_ff) ||
                     (nxt_state == cdmo_pkg::ST_WRITE && dir_ff);
      rw_write_ff <= (nxt_state == cdmo_pkg::ST_WRITE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= 32'h0000_0000;
    end else if (state_ff == cdmo_pkg::ST_READ && src_ack) begin
      data_ff <= dir_ff ? sdram_rdata : card_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign sdram_req = sdram_req_ff;
  assign sdram_write = rw_write_ff;
  assign sdram_addr = cur_addr;
  assign sdram_wdata = data_ff;
  assign card_req = card_req_ff;
  assign card_write = rw_write_ff;
  assign card_wdata = data_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence read_handshake;
    (state_ff == cdmo_pkg::ST_READ) ##0 src_ack;
  endsequence

  sequence write_handshake;
    (state_ff == cdmo_pkg::ST_WRITE) ##0 dst_ack;
  endsequence

  chk_addr_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cdmo_pkg::OFS_ADDR && idle) |=> (cur_addr == $past(pwdata)))
    else $error("start address not loaded");

  chk_addr_advance: assert property (
    @(posedge pclk) disable iff (!presetn)
    write_handshake |=> (cur_addr == $past(cur_addr) + cdmo_pkg::ADDR_STEP))
    else $error("current address did not advance by one word");

  chk_count_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == cdmo_pkg::OFS_COUNT && idle)
      |=> (words_left == $past(pwdata[COUNT_W-1:0])))
    else $error("word count not loaded from low field");

  chk_count_dec: assert property (
    @(posedge pclk) disable iff (!presetn)
    write_handshake |=> (words_left == $past(words_left) - COUNT_W'(1)))
    else $error("word count did not drop by one");

  chk_done_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (done_event && irq_req_en_ff && mask_ff) |-> ##2 irq_ff)
    else $error("completion interrupt not raised");

  chk_done_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (done_event && !irq_req_en_ff) |=> !$rose(done_ff))
    else $error("completion flagged with request disabled");

  chk_dir_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    read_handshake |=> (state_ff == cdmo_pkg::ST_WRITE) && rw_write_ff &&
      (card_req_ff == dir_ff) && (sdram_req_ff == !dir_ff))
    else $error("write side does not follow direction");

  chk_enable_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && enable_ff && words_left != '0) |=> (state_ff == cdmo_pkg::ST_READ) &&
      (sdram_req_ff == dir_ff) && (card_req_ff == !dir_ff))
    else $error("enabled channel did not start");

  chk_disable_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (idle && !enable_ff) |=> idle && !sdram_req_ff && !card_req_ff)
    else $error("disabled channel left idle");

endmodule // cdmo_channel_top

/* File: tb/cdmo_mem_model.sv */
`timescale 1ns/100ps
module cdmo_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] slow,
  input wire logic sdram_req,
  input wire logic sdram_write,
  input wire logic [31:0] sdram_addr,
  input wire logic [31:0] sdram_wdata,
  output logic [31:0] sdram_rdata,
  output logic sdram_ack,
  input wire logic card_req,
  input wire logic card_write,
  input wire logic [31:0] card_wdata,
  output logic [31:0] card_rdata,
  output logic card_ack
);
  // ------------------------------------------------------------
  // Memory and card stream
  // ------------------------------------------------------------
  logic [31:0] mem [0:63];
  logic [31:0] card_got [$];
  logic [31:0] card_next;
  logic [3:0] s_wait;
  logic [3:0] c_wait;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'hA500_0000 + 32'(i);
    end
  end

  // Data lines toggle outside an ack so a stale word never looks fresh
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdram_ack <= 1'b0;
      sdram_rdata <= 32'h0000_0000;
      s_wait <= 4'h0;
    end else begin
      sdram_ack <= 1'b0;
      sdram_rdata <= ~sdram_rdata;
      if (sdram_req && !sdram_ack) begin
        if (s_wait >= slow) begin
          sdram_ack <= 1'b1;
          s_wait <= 4'h0;
          if (sdram_write) begin
            mem[sdram_addr[7:2]] <= sdram_wdata;
          end else begin
            sdram_rdata <= mem[sdram_addr[7:2]];
          end
        end else begin
          s_wait <= s_wait + 4'h1;
        end
      end
    end
  end

  // Card side produces a counting stream and logs what it receives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_ack <= 1'b0;
      card_rdata <= 32'h0000_0000;
      card_next <= 32'hC0DE_0000;
      c_wait <= 4'h0;
    end else begin
      card_ack <= 1'b0;
      card_rdata <= ~card_rdata;
      if (card_req && !card_ack) begin
        if (c_wait >= slow) begin
          card_ack <= 1'b1;
          c_wait <= 4'h0;
          if (card_write) begin
            card_got.push_back(card_wdata);
          end else begin
            card_rdata <= card_next;
            card_next <= card_next + 32'h1;
          end
        end else begin
          c_wait <= c_wait + 4'h1;
        end
      end
    end
  end
endmodule // cdmo_mem_model

/* File: tb/card_dma_channel_one_bench.sv */
`timescale 1ns/100ps
module card_dma_channel_one_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] slow = 4'h0;
  logic [31:0] prdata, sdram_addr, sdram_wdata, sdram_rdata, card_wdata, card_rdata, rd;
  logic pready, pslverr, irq, sdram_req, sdram_write, sdram_ack, card_req, card_write;
  logic card_ack, err;
  int n_mismatch = 0;
  int comparisons = 0;
  int base;
  int n;

  always #20 pclk = ~pclk;

  cdmo_channel_top cdmo_channel_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .sdram_req, .sdram_write, .sdram_addr,
    .sdram_wdata, .sdram_rdata, .sdram_ack, .card_req, .card_write, .card_wdata,
    .card_rdata, .card_ack);

  cdmo_mem_model cdmo_mem_model_i (.pclk, .presetn, .slow, .sdram_req, .sdram_write,
    .sdram_addr, .sdram_wdata, .sdram_rdata, .sdram_ack, .card_req, .card_write,
    .card_wdata, .card_rdata, .card_ack);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("[FAIL] %0t timeout waiting for %s", $time, what);
    summarize();
  endtask

  // One APB transfer; the slave answers when it likes, bounded here
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, what);
    check({31'h0, err}, 32'h0000_0000, "mapped read error");
  endtask

  // Irq is registered behind the status and mask flops
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, {31'h0, exp}, "irq level");
  endtask

  task automatic wait_cards(input int cnt);
    int k;
    k = 0;
    while (cdmo_mem_model_i.card_got.size() < cnt && k < 500) begin
      @(posedge pclk);
      k++;
    end
    if (cdmo_mem_model_i.card_got.size() < cnt) timeout("card words");
    // The word lands with the ack; let the engine count it before looking
    repeat (2) @(posedge pclk);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, cdmo_pkg::OFS_CTRL, 32'h0000_0000);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    if (rd[0] !== 1'b0) timeout("channel idle");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_0000, "addr reset");
    rchk(cdmo_pkg::OFS_COUNT, 32'h0000_0000, "count reset");
    rchk(cdmo_pkg::OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rchk(cdmo_pkg::OFS_STAT, 32'h0000_0000, "status reset");
    rchk(cdmo_pkg::OFS_MASK, 32'h0000_0000, "mask reset");
    apb(1'b1, cdmo_pkg::OFS_ADDR, 32'hFFFF_FFFC);
    rchk(cdmo_pkg::OFS_ADDR, 32'hFFFF_FFFC, "addr full width");
    apb(1'b1, cdmo_pkg::OFS_COUNT, 32'hFFFF_FFFF);
    rchk(cdmo_pkg::OFS_COUNT, 32'h0000_3FFF, "count max");
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'hFFFF_FFF6);
    rchk(cdmo_pkg::OFS_CTRL, 32'h0000_0006, "ctrl bits");
    apb(1'b0, 12'h014, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001, "unmapped error");
    check(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_to_card();
    slow <= 4'h5;
    apb(1'b1, cdmo_pkg::OFS_ADDR, 32'h0000_0010);
    apb(1'b1, cdmo_pkg::OFS_COUNT, 32'h0000_0003);
    apb(1'b1, cdmo_pkg::OFS_MASK, 32'h0000_0001);
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0007);
    wait_cards(1);
    rchk(cdmo_pkg::OFS_COUNT, 32'h0000_0002, "count mid run");
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_0014, "addr mid run");
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      check(cdmo_mem_model_i.card_got[i], 32'hA500_0004 + 32'(i), "card word");
    end
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_001C, "addr end");
    rchk(cdmo_pkg::OFS_COUNT, 32'h0000_0000, "count end");
    rchk(cdmo_pkg::OFS_CTRL, 32'h0000_0006, "enable cleared");
    rchk(cdmo_pkg::OFS_STAT, 32'h0000_0001, "done status");
    irq_is(1'b1);
    apb(1'b1, cdmo_pkg::OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
    apb(1'b1, cdmo_pkg::OFS_MASK, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, cdmo_pkg::OFS_STAT, 32'h0000_0001);
    irq_is(1'b0);
    $display("test to card done");
  endtask

  task automatic t_to_sdram();
    slow <= 4'h0;
    apb(1'b1, cdmo_pkg::OFS_ADDR, 32'h0000_0040);
    apb(1'b1, cdmo_pkg::OFS_COUNT, 32'h0000_0002);
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check(cdmo_mem_model_i.mem[16], 32'hC0DE_0000, "sdram word 0");
    check(cdmo_mem_model_i.mem[17], 32'hC0DE_0001, "sdram word 1");
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_0048, "addr end");
    rchk(cdmo_pkg::OFS_STAT, 32'h0000_0000, "no done status");
    irq_is(1'b0);
    // Count is now zero: enabling completes at once with no word moved
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0005);
    wait_idle();
    rchk(cdmo_pkg::OFS_STAT, 32'h0000_0001, "empty buffer done");
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_0048, "empty buffer addr");
    irq_is(1'b1);
    apb(1'b1, cdmo_pkg::OFS_STAT, 32'h0000_0001);
    irq_is(1'b0);
    $display("test to sdram done");
  endtask

  // Stopping mid buffer may finish the word in flight, no more
  task automatic t_disable();
    slow <= 4'h5;
    base = cdmo_mem_model_i.card_got.size();
    apb(1'b1, cdmo_pkg::OFS_ADDR, 32'h0000_0080);
    apb(1'b1, cdmo_pkg::OFS_COUNT, 32'h0000_0005);
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0003);
    wait_cards(base + 1);
    apb(1'b1, cdmo_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (60) @(posedge pclk);
    n = cdmo_mem_model_i.card_got.size() - base;
    check(32'(n < 5), 32'h0000_0001, "stopped early");
    check({30'h0, sdram_req, card_req}, 32'h0000_0000, "no request");
    rchk(cdmo_pkg::OFS_COUNT, 32'(5 - n), "count left");
    rchk(cdmo_pkg::OFS_ADDR, 32'h0000_0080 + 32'(4 * n), "addr reached");
    $display("test disable done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_to_card();
    t_to_sdram();
    t_disable();
    summarize();
  end
endmodule // card_dma_channel_one_bench
